// File: hw/cps_pkg.sv
/*
  Package for the program-flow and addressing core: address widths, vectors,
  stack depth, pointer map and the carrier structs for its ports.
  Assumes one 50 MHz clock and a synchronous active-low reset.
*/
package cps_pkg;
  localparam int CPS_PC_W = 15;
  localparam int CPS_IMPL_W = 13;
  localparam logic [14:0] CPS_RESET_VEC = 15'h0000;
  localparam logic [14:0] CPS_INT_VEC = 15'h0004;
  localparam logic [14:0] CPS_PC_LAST = 15'h1fff;
  localparam logic [14:0] CPS_HEF_FIRST = 15'h1f80;
  localparam logic [14:0] CPS_HEF_LAST = 15'h1fff;
  localparam int CPS_STK_DEPTH = 16;
  localparam logic [4:0] CPS_STK_FULL = 5'h10;
  localparam logic [4:0] CPS_STK_RST = 5'h00;
  localparam logic [15:0] CPS_PTR_RST = 16'h0000;
  localparam logic [15:0] CPS_PTR_PROG_BASE = 16'h8000;
  localparam logic [15:0] CPS_LIN_BASE = 16'h2000;
  localparam logic [15:0] CPS_LIN_LAST = 16'h29af;
  localparam int CPS_LIN_BANK_BYTES = 80;
  localparam logic [15:0] CPS_LIN_BANK_STRIDE = 16'h0080;
  localparam logic [15:0] CPS_LIN_GPR_OFS = 16'h0020;
  localparam int CPS_NUM_INSTR = 49;
  localparam logic [5:0] CPS_LAST_OPC = 6'h30;

  typedef enum logic [1:0] {
    CPS_ST_RUN = 2'b00,
    CPS_ST_XFETCH = 2'b01
  } cps_state_t;

  // one request from the execution logic per cycle
  typedef struct packed {
    logic step;          // advance pc by one
    logic jump;          // load pc from target
    logic call;          // push return, load target
    logic ret;           // pop into pc
    logic retfie;        // pop and restore shadows
    logic irq;           // interrupt entry
    logic [14:0] target;
    logic [5:0] opcode;  // decoded instruction class
  } cps_flow_t;

  typedef struct packed {
    logic wr;            // write a pointer
    logic sel;           // which pointer
    logic [15:0] value;
    logic ind_use;       // instruction uses the indirect data port
    logic ind_sel;
  } cps_ptr_req_t;

  typedef struct packed {
    logic [7:0] wreg;
    logic [7:0] status;
    logic [7:0] bsr;
    logic [6:0] pc_hi_latch;
  } cps_ctx_t;
endpackage

// File: hw/cps_core.sv
/*
  Program counter, return stack, indirect pointers and shadow context for an
  8-bit CPU core. Assumes the execution logic issues at most one flow request
  per cycle and holds requests while busy is high.
*/
`timescale 1ns/1ps
// Overview of operation
// [R1] pc is 15 bits, spanning a 32K word program space.
// [R2] fetch addresses above 1fffh wrap into the 8192 implemented words.
// [R3] reset starts at 0000h; interrupt entry fetches from 0004h.
// [R4] return stack holds sixteen 15-bit addresses.
// [R5] push on full sets overflow, pop on empty underflow; optional reset.
// [R6] two 16-bit pointers reach every file register and program memory.
// [R7] indirect access to program memory stalls one extra cycle.
// [R8] interrupt entry saves context to shadows; retfie restores it.
// [R9] 1f80h to 1fffh is the high-endurance region, low byte only.
// [R10] linear view maps gpr banks contiguously, beyond 80 bytes.
// [R11] decoder accepts exactly 49 instruction classes.
// [R12] without reset option, flags stay until cleared; pc width kept.
module cps_core (
  input wire logic clk,                        // 50 MHz clock
  input wire logic rst_b,                      // sync reset, active low
  input wire cps_pkg::cps_flow_t flow,         // flow request
  input wire cps_pkg::cps_ptr_req_t ptr_req,   // pointer request
  input wire cps_pkg::cps_ctx_t ctx_in,        // live core context
  input wire logic stk_reset_en,               // stack fault reset option
  input wire logic clr_ovf,                    // software clears overflow
  input wire logic clr_unf,                    // software clears underflow
  output logic [12:0] fetch_addr,              // program array address
  output logic [14:0] pc,                      // full program counter
  output logic [15:0] ptr0,                    // indirect pointer 0
  output logic [15:0] ptr1,                    // indirect pointer 1
  output logic ind_is_prog,                    // pointer targets program
  output logic [12:0] ind_prog_addr,           // program word for pointer
  output logic [11:0] ind_ram_addr,            // banked ram address
  output logic busy,                           // extra fetch cycle
  output logic hef_region,                     // pc in high-endurance area
  output logic stack_overflow_flag,            // sticky overflow
  output logic stack_underflow_flag,           // sticky underflow
  output logic soft_reset,                     // stack fault reset pulse
  output logic illegal_opc,                    // unsupported instruction
  output cps_pkg::cps_ctx_t ctx_restore,       // shadow copy
  output logic ctx_restore_vld                 // restore strobe
);
  import cps_pkg::*;

  typedef struct packed {
    logic [14:0] pc;
    logic [4:0] sp;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic ovf;
    logic unf;
    logic srst;
    logic restore;
    cps_ctx_t shadow;
    cps_state_t st;
  } cps_core_state_t;

  cps_core_state_t s_q, s_d;
  logic [14:0] stk_q [CPS_STK_DEPTH];
  logic push, pop, full, empty;
  logic [15:0] sel_ptr;

  // linear gpr view: 80 bytes per bank placed end to end
  function automatic logic [11:0] cps_lin2bank(input logic [15:0] a);
    logic [15:0] off;
    logic [15:0] bank;
    logic [15:0] idx;
    off = a - CPS_LIN_BASE;
    bank = off / 16'(CPS_LIN_BANK_BYTES);
    idx = off % 16'(CPS_LIN_BANK_BYTES);
    cps_lin2bank = 12'(bank * CPS_LIN_BANK_STRIDE + CPS_LIN_GPR_OFS + idx);
  endfunction

  // true when the pointer reaches program memory
  function automatic logic cps_is_prog(input logic [15:0] a);
    cps_is_prog = a[15];
  endfunction

  assign full = (s_q.sp == CPS_STK_FULL);
  assign empty = (s_q.sp == CPS_STK_RST);
  assign push = flow.call | flow.irq;
  assign pop = flow.ret | flow.retfie;
  assign sel_ptr = ptr_req.ind_sel ? s_q.ptr1 : s_q.ptr0;

  always_comb begin
    s_d = s_q;
    s_d.srst = 1'b0;
    s_d.restore = 1'b0;
    if (clr_ovf) s_d.ovf = 1'b0;
    if (clr_unf) s_d.unf = 1'b0;
    unique case (s_q.st)
      CPS_ST_RUN: begin
        if (ptr_req.ind_use && cps_is_prog(sel_ptr)) begin
          s_d.st = CPS_ST_XFETCH; // R7
        end else if (flow.irq) begin
          s_d.pc = CPS_INT_VEC; // R3
          s_d.shadow = ctx_in; // R8
        end else if (flow.call || flow.jump) begin
          s_d.pc = flow.target; // R1
        end else if (pop) begin
          if (!empty) begin
            s_d.pc = stk_q[4'(s_q.sp - 5'h01)]; // R4
          end
          s_d.restore = flow.retfie; // R8
        end else if (flow.step) begin
          s_d.pc = s_q.pc + 15'h0001; // R1
        end
        if (!(ptr_req.ind_use && cps_is_prog(sel_ptr))) begin
          if (push) begin
            if (full) s_d.ovf = 1'b1; // R5
            else s_d.sp = s_q.sp + 5'h01; // R12
          end
          if (pop) begin
            if (empty) s_d.unf = 1'b1; // R5
            else s_d.sp = s_q.sp - 5'h01; // R12
          end
          s_d.srst = stk_reset_en && ((push && full) || (pop && empty)); // R5
        end
      end
      CPS_ST_XFETCH: begin
        s_d.st = CPS_ST_RUN; // R7
      end
      default: s_d.st = CPS_ST_RUN;
    endcase
    if (ptr_req.wr) begin
      if (ptr_req.sel) s_d.ptr1 = ptr_req.value; // R6
      else s_d.ptr0 = ptr_req.value; // R6
    end
    if (s_q.srst) begin
      // software reset restarts fetch but leaves the flags for inspection
      s_d.pc = CPS_RESET_VEC; // R3
      s_d.sp = CPS_STK_RST;
      s_d.st = CPS_ST_RUN;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.pc <= CPS_RESET_VEC; // R3
      s_q.sp <= CPS_STK_RST;
      s_q.ptr0 <= CPS_PTR_RST;
      s_q.ptr1 <= CPS_PTR_RST;
      s_q.st <= CPS_ST_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // stack array has no reset; pointer guards every read
  always_ff @(posedge clk) begin
    if (rst_b && s_q.st == CPS_ST_RUN && push && !full && !s_q.srst
        && !(ptr_req.ind_use && cps_is_prog(sel_ptr))) begin
      stk_q[4'(s_q.sp)] <= flow.irq ? s_q.pc : s_q.pc + 15'h0001; // R4
    end
  end

  assign pc = s_q.pc;
  assign fetch_addr = s_q.pc[CPS_IMPL_W-1:0]; // R2
  assign ptr0 = s_q.ptr0;
  assign ptr1 = s_q.ptr1;
  assign ind_is_prog = cps_is_prog(sel_ptr); // R6
  assign ind_prog_addr = sel_ptr[CPS_IMPL_W-1:0]; // R2
  assign ind_ram_addr = (sel_ptr >= CPS_LIN_BASE && sel_ptr <= CPS_LIN_LAST)
      ? cps_lin2bank(sel_ptr) : sel_ptr[11:0]; // R10
  assign busy = (s_q.st == CPS_ST_XFETCH); // R7
  assign hef_region = ({2'b00, fetch_addr} >= CPS_HEF_FIRST)
      && ({2'b00, fetch_addr} <= CPS_HEF_LAST); // R9
  assign stack_overflow_flag = s_q.ovf;
  assign stack_underflow_flag = s_q.unf;
  assign soft_reset = s_q.srst;
  assign illegal_opc = (flow.opcode > CPS_LAST_OPC); // R11
  assign ctx_restore = s_q.shadow;
  assign ctx_restore_vld = s_q.restore;

  // a plain step off the last implemented word must land on word zero
  chk_wrap_fetch: assert property (@(posedge clk) disable iff (!rst_b) // R2
      (s_q.st == CPS_ST_RUN && flow.step && !flow.jump && !push && !pop
      && !(ptr_req.ind_use && ind_is_prog) && !s_q.srst
      && fetch_addr == CPS_PC_LAST[12:0]) |=> fetch_addr == 13'h0000)
      else $error("fetch did not wrap past 1fffh");
  chk_irq_vector: assert property (@(posedge clk) disable iff (!rst_b) // R3
      (s_q.st == CPS_ST_RUN && flow.irq && !ptr_req.ind_use && !s_q.srst)
      |=> pc == 15'h0004) else $error("irq not at vector");
  chk_ovf_set: assert property (@(posedge clk) disable iff (!rst_b) // R5
      (s_q.st == CPS_ST_RUN && push && full && !ptr_req.ind_use)
      |=> stack_overflow_flag) else $error("overflow missed");
  chk_unf_set: assert property (@(posedge clk) disable iff (!rst_b) // R5
      (s_q.st == CPS_ST_RUN && pop && empty && !ptr_req.ind_use)
      |=> stack_underflow_flag) else $error("underflow missed");
  chk_sp_bound: assert property (@(posedge clk) disable iff (!rst_b) // R4
      s_q.sp <= CPS_STK_FULL) else $error("stack pointer out of range");
  chk_xfetch_one: assert property (@(posedge clk) disable iff (!rst_b) // R7
      busy |=> !busy) else $error("extra cycle too long");
  chk_restore_ctx: assert property (@(posedge clk) disable iff (!rst_b) // R8
      ctx_restore_vld |-> $past(flow.retfie)) else $error("bad restore");
  chk_flag_hold: assert property (@(posedge clk) disable iff (!rst_b) // R12
      (stack_overflow_flag && !clr_ovf) |=> stack_overflow_flag)
      else $error("overflow flag dropped");
  // set wins over clear, so a fault reset always shows its flag
  chk_srst_cause: assert property (@(posedge clk) disable iff (!rst_b) // R5
      soft_reset |-> $past(stk_reset_en)
      && (stack_overflow_flag || stack_underflow_flag))
      else $error("spurious reset");
  chk_hef_range: assert property (@(posedge clk) disable iff (!rst_b) // R9
      hef_region |-> fetch_addr[12:7] == 6'h3f) else $error("hef map");
endmodule // cps_core

// File: sim/cps_mem_model.sv
/*
  Program flash array model: returns a fixed word pattern per address.
  Assumes the core presents a 13-bit wrapped fetch address.
*/
`timescale 1ns/1ps
module cps_mem_model (
  input wire logic [12:0] addr, // fetch address
  output logic [13:0] word      // 14-bit program word
);
  // only 8192 words exist, so no wider address reaches here
  assign word = {1'b0, addr} ^ 14'h2a5a;
endmodule // cps_mem_model

// File: sim/cps_core_tb.sv
/*
  Testbench for cps_core: integer and queue model of pc and return stack.
  Assumes design outputs settle within 1 ns of the taken edge.
*/
`timescale 1ns/1ps
module cps_core_tb;
  import cps_pkg::*;
  logic clk = 0, rst_b = 0, stk_reset_en = 0, clr_ovf = 0, clr_unf = 0;
  cps_flow_t flow = '0;
  cps_ptr_req_t ptr_req = '0;
  cps_ctx_t ctx_in = '0, ctx_restore;
  logic [12:0] fetch_addr, ind_prog_addr;
  logic [14:0] pc;
  logic [15:0] ptr0, ptr1;
  logic [11:0] ind_ram_addr;
  logic [13:0] word;
  logic ind_is_prog, busy, hef_region, stack_overflow_flag;
  logic stack_underflow_flag, soft_reset, illegal_opc, ctx_restore_vld;
  int mismatches = 0, check_count = 0, mpc = 0, ovf = 0, unf = 0, i, s;
  int stk[$];
  cps_core u_cps_core (.clk(clk), .rst_b(rst_b), .flow(flow),
    .ptr_req(ptr_req), .ctx_in(ctx_in), .stk_reset_en(stk_reset_en),
    .clr_ovf(clr_ovf), .clr_unf(clr_unf), .fetch_addr(fetch_addr), .pc(pc),
    .ptr0(ptr0), .ptr1(ptr1), .ind_is_prog(ind_is_prog),
    .ind_prog_addr(ind_prog_addr), .ind_ram_addr(ind_ram_addr),
    .busy(busy), .hef_region(hef_region),
    .stack_overflow_flag(stack_overflow_flag),
    .stack_underflow_flag(stack_underflow_flag), .soft_reset(soft_reset),
    .illegal_opc(illegal_opc), .ctx_restore(ctx_restore),
    .ctx_restore_vld(ctx_restore_vld));
  cps_mem_model u_cps_mem_model (.addr(fetch_addr), .word(word));
  initial forever #10 clk = ~clk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one flow request, model update, then compare the settled outputs
  task go(input cps_flow_t f);
    int sr;
    sr = 0;
    @(posedge clk) flow <= f;
    @(posedge clk) flow <= '0;
    #1;
    if (f.irq) begin stk.push_back(mpc); mpc = 4; end
    else if (f.call) begin
      if (stk.size() == 16) begin ovf = 1; sr = stk_reset_en; end
      else stk.push_back((mpc + 1) % 32768);
      mpc = f.target;
    end else if (f.jump) mpc = f.target;
    else if (f.ret || f.retfie) begin
      if (stk.size() == 0) begin unf = 1; sr = stk_reset_en; end
      else mpc = stk.pop_back();
    end else if (f.step) mpc = (mpc + 1) % 32768;
    chk("pc", mpc, pc);
    chk("fetch", mpc % 8192, fetch_addr);
    chk("word", (mpc % 8192) ^ 32'h2a5a, word);
    chk("hef", (mpc % 8192) >= 32'h1f80, hef_region);
    chk("ovf", ovf, stack_overflow_flag);
    chk("unf", unf, stack_underflow_flag);
    chk("srst", sr, soft_reset);
    chk("ctx_vld_go", f.retfie, ctx_restore_vld);
    if (sr) begin
      @(posedge clk) #1;
      mpc = 0;
      stk.delete();
      chk("pc_srst", 0, pc);
    end
  endtask
  task clr;
    @(posedge clk) begin clr_ovf <= 1; clr_unf <= 1; end
    @(posedge clk) begin clr_ovf <= 0; clr_unf <= 0; end
    #1 ovf = 0;
    unf = 0;
    chk("ovf_clr", 0, stack_overflow_flag);
    chk("unf_clr", 0, stack_underflow_flag);
  endtask
  function automatic cps_flow_t fl(int k, logic [14:0] t);
    fl = '0;
    fl[26 - k] = 1'b1; // k: 0 step 1 jump 2 call 3 ret 4 retfie 5 irq
    fl.target = t;
  endfunction
  initial begin
    s = $urandom(32'hf2f35985);
    repeat (4) @(posedge clk);
    rst_b <= 1;
    @(posedge clk) #1 chk("pc_rst", 0, pc);
    go(fl(0, 0));
    go(fl(1, {2'b11, 13'($urandom)}));
    go(fl(1, 15'h1f80));
    go(fl(1, 15'h1f7f));
    go(fl(0, 0));
    @(posedge clk) ctx_in <= cps_ctx_t'(31'($urandom));
    go(fl(5, 0));
    go(fl(4, 0));
    chk("ctx_vld", 1, ctx_restore_vld);
    chk("ctx", ctx_in, ctx_restore);
    for (i = 47; i < 51; i++) begin
      @(posedge clk) flow.opcode <= 6'(i);
      #1 chk("illegal", i > 48, illegal_opc);
    end
    for (i = 0; i < 17; i++) go(fl(2, 15'($urandom)));
    clr;
    for (i = 0; i < 17; i++) go(fl(3, 0));
    clr;
    @(posedge clk) stk_reset_en <= 1;
    for (i = 0; i < 17; i++) go(fl(2, 15'($urandom)));
    go(fl(3, 0));
    clr;
    s = $urandom;
    @(posedge clk) ptr_req <= {1'b1, 1'b0, 3'b100, 13'(s), 2'b00};
    @(posedge clk) ptr_req <= {1'b1, 1'b1, 16'h2055, 2'b00};
    @(posedge clk) ptr_req <= {1'b0, 1'b0, 16'h0000, 2'b10};
    #1 chk("ptr0", {3'b100, 13'(s)}, ptr0);
    chk("ptr1", 16'h2055, ptr1);
    chk("isprog", 1, ind_is_prog);
    chk("paddr", 13'(s), ind_prog_addr);
    chk("ramad0", 12'(s), ind_ram_addr);
    // a jump offered while busy must be ignored
    @(posedge clk) begin
      ptr_req <= {1'b0, 1'b0, 16'h0000, 2'b01};
      flow <= fl(1, 15'h0123);
    end
    #1 chk("busy", 1, busy);
    chk("ramad", 12'h0a5, ind_ram_addr);
    chk("isprog1", 0, ind_is_prog);
    @(posedge clk) begin
      ptr_req <= '0;
      flow <= '0;
    end
    #1 chk("busy_off", 0, busy);
    chk("pc_busy", mpc, pc);
    go(fl(1, 15'h3fff));
    go(fl(0, 0));
    @(posedge clk) rst_b <= 0;
    @(posedge clk) rst_b <= 1;
    #1 chk("pc_rst2", 0, pc);
    chk("ptr0_rst", 0, ptr0);
    test_done;
  end
  initial begin
    #100us;
    mismatches++;
    test_done;
  end
endmodule // cps_core_tb
